// file: rtl/dts_pkg.sv
// Purpose: shared constants and carriers for draw target select and write mask
// Assumes: one 250 MHz clock, synchronous active-high reset
// Notes:   selector codes are block-local encodings
package dts_pkg;
  localparam int unsigned MAX_TARGETS    = 4;
  localparam int unsigned MAX_ATTACH     = 4;
  localparam int unsigned AUX_COUNT      = 2;
  localparam int unsigned IDX_W          = 8;
  localparam int unsigned STEN_W         = 8;
  localparam int unsigned BUF_W          = 4 + AUX_COUNT + MAX_ATTACH;

  // selector encodings
  localparam logic [4:0] SEL_NONE        = 5'h00;
  localparam logic [4:0] SEL_FL          = 5'h01;
  localparam logic [4:0] SEL_FR          = 5'h02;
  localparam logic [4:0] SEL_BL          = 5'h03;
  localparam logic [4:0] SEL_BR          = 5'h04;
  localparam logic [4:0] SEL_FRONT       = 5'h05;
  localparam logic [4:0] SEL_BACK        = 5'h06;
  localparam logic [4:0] SEL_LEFT        = 5'h07;
  localparam logic [4:0] SEL_RIGHT       = 5'h08;
  localparam logic [4:0] SEL_FAB         = 5'h09;
  localparam logic [4:0] SEL_AUX0        = 5'h0a;
  localparam logic [4:0] SEL_ATT0        = 5'h10;

  // error codes
  localparam logic [1:0] ERR_NONE        = 2'h0;
  localparam logic [1:0] ERR_SELECTOR    = 2'h1;
  localparam logic [1:0] ERR_VALUE       = 2'h2;
  localparam logic [1:0] ERR_OPERATION   = 2'h3;

  // register byte offsets
  localparam logic [7:0] OFF_CMD_LIST    = 8'h00;
  localparam logic [7:0] OFF_CMD_SINGLE  = 8'h04;
  localparam logic [7:0] OFF_CMD_CMASK   = 8'h08;
  localparam logic [7:0] OFF_CMD_CMASKALL= 8'h0c;
  localparam logic [7:0] OFF_INDEX_MASK  = 8'h10;
  localparam logic [7:0] OFF_DEPTH_EN    = 8'h14;
  localparam logic [7:0] OFF_STEN_SIDED  = 8'h18;
  localparam logic [7:0] OFF_STEN_BOTH   = 8'h1c;
  localparam logic [7:0] OFF_ERROR       = 8'h20;
  localparam logic [7:0] OFF_TARGET0     = 8'h24;
  localparam logic [7:0] OFF_TARGETS     = 8'h28;
  localparam logic [7:0] OFF_CMASKS      = 8'h2c;
  localparam logic [7:0] OFF_STEN_RD     = 8'h30;

  localparam logic [1:0] FACE_FRONT      = 2'h1;
  localparam logic [1:0] FACE_BACK       = 2'h2;
  localparam logic [1:0] FACE_BOTH       = 2'h3;

  typedef struct packed {
    logic              valid;
    logic              back_facing;
    logic              is_clear;
    logic [MAX_TARGETS-1:0] color_written;
    logic              single_output;
  } dts_frag_s;

  typedef struct packed {
    logic [MAX_TARGETS-1:0][BUF_W-1:0] buf_en;
    logic [MAX_TARGETS-1:0][3:0]       comp_en;
    logic [IDX_W-1:0]                  index_mask;
    logic                              depth_en;
    logic [STEN_W-1:0]                 sten_mask;
    logic [MAX_TARGETS-1:0]            src_sel;
  } dts_wr_s;
endpackage

// file: rtl/dts_top.sv
// Purpose: draw target selection, validation and per-buffer write masks
// Assumes: registers over AXI4-Lite; configuration straps are static
// Notes:   commands are register writes; errors are sticky until read
//
// What this block does
// - list maps targets in order, rest none
// - list length above maximum: bad value
// - repeated non-none buffer: bad operation
// - multi-buffer selectors in list: bad selector
// - default fb unallocated buffer: bad operation
// - attachment fb bad selector: bad operation; single select past last attachment: bad value
// - empty attachment slot writes nothing
// - none suppresses; others reach selected buffers
// - buffers present follow stereo and double
// - reset targets: back/front/none or slot zero
// - targets readable by index, colour zero
// - index mask gates index bits
// - four component enables per target
// - multi-buffer target shares component enables
// - unindexed colour mask sets all targets
// - colour mask index too high: bad value
// - depth write bit, set at reset
// - front and back stencil masks, face select
// - facing picks mask; clears use front
// - masks all ones at reset
// - multisample: masks govern samples, resolve always
// - single output broadcast, multiple separate
// - single select sets zero, others none
`timescale 1ns/1ps
module dts_top (
  input  wire logic                  ref_clk_i,
  input  wire logic                  srst_i,
  input  wire logic                  stereo_i,
  input  wire logic                  double_i,
  input  wire logic                  default_fb_i,
  input  wire logic                  has_default_fb_i,
  input  wire logic [dts_pkg::MAX_ATTACH-1:0] attach_present_i,
  input  wire logic                  multisample_i,
  input  wire dts_pkg::dts_frag_s    frag_i,
  output dts_pkg::dts_wr_s           wr_o,
  output logic                       wr_valid_o,
  output logic                       resolve_o,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready
);
  localparam int unsigned NT = dts_pkg::MAX_TARGETS;
  localparam int unsigned BW = dts_pkg::BUF_W;

  logic [NT-1:0][4:0]         target_reg;
  logic [NT-1:0][3:0]         cmask_reg;
  logic [dts_pkg::IDX_W-1:0]  index_mask_reg;
  logic                       depth_en_reg;
  logic [dts_pkg::STEN_W-1:0] sten_front_reg;
  logic [dts_pkg::STEN_W-1:0] sten_back_reg;
  logic [1:0]                 error_reg;
  logic [7:0]                 aw_reg;
  logic [31:0]                wd_reg;
  logic                       aw_have_reg;
  logic                       w_have_reg;

  ////////////////////////////////////////////////////////////////////////
  // selector helpers
  function automatic logic [BW-1:0] decode_sel(input logic [4:0] s);
    logic [BW-1:0] v;
    v = '0;
    case (s)
      dts_pkg::SEL_FL:    v[0] = 1'b1;
      dts_pkg::SEL_FR:    v[1] = 1'b1;
      dts_pkg::SEL_BL:    v[2] = 1'b1;
      dts_pkg::SEL_BR:    v[3] = 1'b1;
      dts_pkg::SEL_FRONT: v[1:0] = 2'h3;
      dts_pkg::SEL_BACK:  v[3:2] = 2'h3;
      dts_pkg::SEL_LEFT:  v[3:0] = 4'h5;
      dts_pkg::SEL_RIGHT: v[3:0] = 4'ha;
      dts_pkg::SEL_FAB:   v[3:0] = 4'hf;
      default: begin
        if (s >= dts_pkg::SEL_ATT0 && s < dts_pkg::SEL_ATT0 + 5'(dts_pkg::MAX_ATTACH))
          v[4 + dts_pkg::AUX_COUNT + int'(s - dts_pkg::SEL_ATT0)] = 1'b1;
        else if (s >= dts_pkg::SEL_AUX0 && s < dts_pkg::SEL_AUX0 + 5'(dts_pkg::AUX_COUNT))
          v[4 + int'(s - dts_pkg::SEL_AUX0)] = 1'b1;
      end
    endcase
    return v;
  endfunction

  // buffers this context owns: left always, right if stereo, back if double
  logic [BW-1:0] present;
  always_comb begin
    present = '0;
    present[0] = 1'b1;
    present[1] = stereo_i;
    present[2] = double_i;
    present[3] = double_i & stereo_i;
    present[4 +: dts_pkg::AUX_COUNT] = '1;
    present[4 + dts_pkg::AUX_COUNT +: dts_pkg::MAX_ATTACH] = attach_present_i;
  end

  // 0 ok, else error code for one list entry
  function automatic logic [1:0] check_sel(input logic [4:0] s, input logic dfb,
                                            input logic [BW-1:0] pres);
    logic [BW-1:0] v;
    v = decode_sel(s);
    if (s == dts_pkg::SEL_NONE)
      return dts_pkg::ERR_NONE;
    if (s >= dts_pkg::SEL_FRONT && s <= dts_pkg::SEL_FAB)
      return dts_pkg::ERR_SELECTOR;
    if (dfb) begin
      if (s >= dts_pkg::SEL_ATT0 || v == '0 || (v & pres) == '0)
        return dts_pkg::ERR_OPERATION;
    end else if (s < dts_pkg::SEL_ATT0 || v == '0) begin
      return dts_pkg::ERR_OPERATION;
    end
    return dts_pkg::ERR_NONE;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write: address and data taken in either order
  logic wr_fire;
  assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_reg && !s_axi_bvalid;
  assign wr_fire       = aw_have_reg && w_have_reg && !s_axi_bvalid;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      aw_reg      <= 8'h00;
      wd_reg      <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        aw_reg      <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        wd_reg     <= s_axi_wdata;
      end
      if (wr_fire) begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_bresp = 2'h0;

  ////////////////////////////////////////////////////////////////////////
  // command evaluation; list word: [2:0] length, [8+5i +: 5] entry i
  logic [NT-1:0][4:0] list_next;
  logic [1:0]         cmd_err;
  logic [2:0]         list_len;

  always_comb begin
    list_next = target_reg;
    cmd_err   = dts_pkg::ERR_NONE;
    list_len  = wd_reg[2:0];
    case (aw_reg)
      dts_pkg::OFF_CMD_LIST: begin
        if (32'(list_len) > NT)
          cmd_err = dts_pkg::ERR_VALUE;
        for (int i = 0; i < NT; i++) begin
          list_next[i] = (i < int'(list_len)) ? wd_reg[8 + 5*i +: 5] : dts_pkg::SEL_NONE;
          if (cmd_err == dts_pkg::ERR_NONE)
            cmd_err = check_sel(list_next[i], default_fb_i, present);
          for (int j = 0; j < i; j++)
            if (cmd_err == dts_pkg::ERR_NONE && list_next[i] != dts_pkg::SEL_NONE &&
                list_next[i] == list_next[j])
              cmd_err = dts_pkg::ERR_OPERATION;
        end
      end
      dts_pkg::OFF_CMD_SINGLE: begin
        list_next    = '0;
        list_next[0] = wd_reg[4:0];
        if (wd_reg[4:0] != dts_pkg::SEL_NONE) begin
          if (default_fb_i && (wd_reg[4:0] >= dts_pkg::SEL_ATT0 ||
                               (decode_sel(wd_reg[4:0]) & present) == '0))
            cmd_err = dts_pkg::ERR_OPERATION;
          else if (!default_fb_i && wd_reg[4:0] < dts_pkg::SEL_ATT0)
            cmd_err = dts_pkg::ERR_OPERATION;
          else if (!default_fb_i && decode_sel(wd_reg[4:0]) == '0)
            cmd_err = dts_pkg::ERR_VALUE;
        end
      end
      dts_pkg::OFF_CMD_CMASK: begin
        if (wd_reg[31:8] > 24'(NT - 1))
          cmd_err = dts_pkg::ERR_VALUE;
      end
      default: ;
    endcase
  end

  // error held until read; a new error in the read cycle wins
  logic rd_err_take;
  always_ff @(posedge ref_clk_i) begin
    if (srst_i)
      error_reg <= dts_pkg::ERR_NONE;
    else if (wr_fire && cmd_err != dts_pkg::ERR_NONE &&
             (error_reg == dts_pkg::ERR_NONE || rd_err_take))
      error_reg <= cmd_err;
    else if (rd_err_take)
      error_reg <= dts_pkg::ERR_NONE;
  end

  logic cmd_ok;
  assign cmd_ok = wr_fire && cmd_err == dts_pkg::ERR_NONE;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      target_reg <= '0;
      if (!default_fb_i)
        target_reg[0] <= dts_pkg::SEL_ATT0;
      else if (has_default_fb_i)
        target_reg[0] <= double_i ? dts_pkg::SEL_BACK : dts_pkg::SEL_FRONT;
    end else if (cmd_ok && (aw_reg == dts_pkg::OFF_CMD_LIST ||
                            aw_reg == dts_pkg::OFF_CMD_SINGLE)) begin
      target_reg <= list_next;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      cmask_reg <= '1;
    end else if (cmd_ok && aw_reg == dts_pkg::OFF_CMD_CMASK) begin
      cmask_reg[wd_reg[$clog2(NT)+7:8]] <= wd_reg[3:0];
    end else if (cmd_ok && aw_reg == dts_pkg::OFF_CMD_CMASKALL) begin
      for (int i = 0; i < NT; i++)
        cmask_reg[i] <= wd_reg[3:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      index_mask_reg <= '1;
      depth_en_reg   <= 1'b1;
      sten_front_reg <= '1;
      sten_back_reg  <= '1;
    end else if (cmd_ok) begin
      case (aw_reg)
        dts_pkg::OFF_INDEX_MASK: index_mask_reg <= wd_reg[dts_pkg::IDX_W-1:0];
        dts_pkg::OFF_DEPTH_EN:   depth_en_reg   <= |wd_reg;
        dts_pkg::OFF_STEN_BOTH: begin
          sten_front_reg <= wd_reg[dts_pkg::STEN_W-1:0];
          sten_back_reg  <= wd_reg[dts_pkg::STEN_W-1:0];
        end
        dts_pkg::OFF_STEN_SIDED: begin
          if (wd_reg[9:8] == dts_pkg::FACE_FRONT || wd_reg[9:8] == dts_pkg::FACE_BOTH)
            sten_front_reg <= wd_reg[dts_pkg::STEN_W-1:0];
          if (wd_reg[9:8] == dts_pkg::FACE_BACK || wd_reg[9:8] == dts_pkg::FACE_BOTH)
            sten_back_reg  <= wd_reg[dts_pkg::STEN_W-1:0];
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // fragment write enables, registered one cycle
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      wr_o       <= '0;
      wr_valid_o <= 1'b0;
      resolve_o  <= 1'b0;
    end else begin
      wr_valid_o <= frag_i.valid;
      resolve_o  <= frag_i.valid && multisample_i;
      wr_o.index_mask <= index_mask_reg;
      wr_o.depth_en   <= depth_en_reg;
      wr_o.sten_mask  <= (frag_i.back_facing && !frag_i.is_clear) ?
                         sten_back_reg : sten_front_reg;
      for (int i = 0; i < NT; i++) begin
        // masks govern the sample store; resolve still writes targeted buffers
        wr_o.buf_en[i]  <= decode_sel(target_reg[i]) & present;
        wr_o.comp_en[i] <= cmask_reg[i];
        wr_o.src_sel[i] <= frag_i.single_output ? 1'b0 : 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read
  logic [31:0] rd_word;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_err_take   = s_axi_arvalid && s_axi_arready && s_axi_araddr == dts_pkg::OFF_ERROR;

  always_comb begin
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      dts_pkg::OFF_ERROR:      rd_word[1:0] = error_reg;
      dts_pkg::OFF_TARGET0:    rd_word[4:0] = target_reg[0];
      dts_pkg::OFF_TARGETS:    rd_word[5*NT-1:0] = target_reg;
      dts_pkg::OFF_CMASKS:     rd_word[4*NT-1:0] = cmask_reg;
      dts_pkg::OFF_INDEX_MASK: rd_word[dts_pkg::IDX_W-1:0] = index_mask_reg;
      dts_pkg::OFF_DEPTH_EN:   rd_word[0] = depth_en_reg;
      dts_pkg::OFF_STEN_RD:    rd_word[15:0] = {sten_back_reg, sten_front_reg};
      default: ;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_rresp = 2'h0;

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_error_blocks_state: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    wr_fire && cmd_err != dts_pkg::ERR_NONE |=> $stable(target_reg) && $stable(cmask_reg))
    else $error("erroring command changed state");
  a_len_too_big: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    wr_fire && aw_reg == dts_pkg::OFF_CMD_LIST && 32'(wd_reg[2:0]) > NT &&
    error_reg == dts_pkg::ERR_NONE |=> error_reg == dts_pkg::ERR_VALUE)
    else $error("long list not flagged");
  a_single_clears: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    cmd_ok && aw_reg == dts_pkg::OFF_CMD_SINGLE |=> target_reg[NT-1] == dts_pkg::SEL_NONE)
    else $error("single select left other targets");
  a_mask_all_set: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    cmd_ok && aw_reg == dts_pkg::OFF_CMD_CMASKALL |=> cmask_reg[NT-1] == $past(wd_reg[3:0]))
    else $error("all-mask not applied");
  a_cmask_index: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    wr_fire && aw_reg == dts_pkg::OFF_CMD_CMASK && wd_reg[31:8] >= 24'(NT) &&
    error_reg == dts_pkg::ERR_NONE |=> error_reg == dts_pkg::ERR_VALUE)
    else $error("bad mask index not flagged");
  a_none_no_write: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    frag_i.valid && target_reg[1] == dts_pkg::SEL_NONE |=> wr_o.buf_en[1] == '0)
    else $error("none target wrote");
  a_face_mask: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    frag_i.valid && frag_i.back_facing && !frag_i.is_clear && !cmd_ok
    |=> wr_o.sten_mask == sten_back_reg)
    else $error("back fragment used wrong mask");
  a_depth_reset: assert property (@(posedge ref_clk_i)
    $fell(srst_i) |-> depth_en_reg && index_mask_reg == '1)
    else $error("reset masks wrong");
endmodule

// file: bench/dts_frag_src.sv
// Purpose: fragment pipeline stand-in driving one fragment per request
// Assumes: requests arrive as one-cycle go pulses
// Notes:   idle fields toggle so stale values never look valid
`timescale 1ns/1ps
module dts_frag_src (
  input  wire logic          ref_clk_i,
  input  wire logic          go_i,
  input  wire logic          back_i,
  input  wire logic          clr_i,
  input  wire logic          single_i,
  output dts_pkg::dts_frag_s frag_o = '0
);
  always @(posedge ref_clk_i) begin
    if (go_i) begin
      frag_o <= {1'b1, back_i, clr_i, 4'hf, single_i};
    end else begin
      frag_o <= {1'b0, ~frag_o[6:0]};
    end
  end
endmodule

// file: bench/tb_draw_target_select_and_write_mask.sv
// Purpose: self-checking bench for target selection and write masks
// Assumes: stereo, double buffered context at start; commands over AXI4-Lite
// Notes:   later resets switch to attachments, then mono single buffered
`timescale 1ns/1ps
module tb_draw_target_select_and_write_mask;
  logic               clk = 1'b0;
  logic               srst = 1'b1;
  logic               dfb = 1'b1;
  logic [3:0]         att = 4'hf;
  logic               go = 1'b0;
  logic               bk = 1'b0;
  logic               cl = 1'b0;
  logic               so = 1'b0;
  logic               ms = 1'b0;
  logic               st = 1'b1;
  logic               db = 1'b1;
  logic               hdf = 1'b1;
  logic [7:0]         awaddr = 8'h00;
  logic [7:0]         araddr = 8'h00;
  logic [31:0]        wdata = 32'h0;
  logic [3:0]         strb = 4'hf;
  logic               awvalid = 1'b0;
  logic               wvalid = 1'b0;
  logic               bready = 1'b0;
  logic               arvalid = 1'b0;
  logic               rready = 1'b0;
  logic               awready, wready, bvalid, arready, rvalid, wv, rs;
  logic [1:0]         bresp, rresp;
  logic [31:0]        rdata;
  dts_pkg::dts_frag_s frag;
  dts_pkg::dts_wr_s   wr;
  int                 mismatches = 0;
  int                 tests_run = 0;

  initial begin
    forever #2 clk = ~clk;
  end

  dts_top dts_top_inst (.ref_clk_i(clk), .srst_i(srst), .stereo_i(st), .double_i(db),
    .default_fb_i(dfb), .has_default_fb_i(hdf), .attach_present_i(att),
    .multisample_i(ms), .frag_i(frag), .wr_o(wr), .wr_valid_o(wv), .resolve_o(rs),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  dts_frag_src dts_frag_src_inst (.ref_clk_i(clk), .go_i(go), .back_i(bk), .clr_i(cl),
    .single_i(so), .frag_o(frag));

  ////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("compares %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int   n;
    logic ta, tw, tb;
    n = 0;
    tb = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // handshakes judged just before the edge that takes them
    while (!tb && n < 50) begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
      n++;
    end
    if (!tb) begin
      mismatches++;
      test_done();
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    int   n;
    logic ta, tr;
    n = 0;
    tr = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!tr && n < 50) begin
      @(negedge clk);
      ta = arvalid && arready;
      tr = rvalid;
      d = rdata;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
      n++;
    end
    if (!tr) begin
      mismatches++;
      test_done();
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    axi_rd(a, d);
    chk(d, exp);
  endtask

  function automatic logic [31:0] lw(input logic [2:0] n, input logic [4:0] e0, e1);
    return (32'(e1) << 13) | (32'(e0) << 8) | 32'(n);
  endfunction

  task automatic frag_go(input logic b, input logic c);
    @(posedge clk);
    go <= 1'b1;
    bk <= b;
    cl <= c;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    #1;
    chk(32'(wv), 32'h1);
  endtask

  task automatic do_reset();
    srst <= 1'b1;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset_vals();
    rd_chk(dts_pkg::OFF_TARGET0, 32'(dts_pkg::SEL_BACK));
    rd_chk(dts_pkg::OFF_CMASKS, 32'h0000ffff);
    rd_chk(dts_pkg::OFF_STEN_RD, 32'h0000ffff);
    rd_chk(dts_pkg::OFF_INDEX_MASK, 32'h000000ff);
    rd_chk(dts_pkg::OFF_DEPTH_EN, 32'h00000001);
    rd_chk(8'h40, 32'h0);
  endtask

  task automatic t_list();
    axi_wr(dts_pkg::OFF_CMD_LIST, lw(3'h2, dts_pkg::SEL_FL, dts_pkg::SEL_BL));
    rd_chk(dts_pkg::OFF_ERROR, 32'h0);
    rd_chk(dts_pkg::OFF_TARGETS, 32'h00000061);
    rd_chk(dts_pkg::OFF_TARGET0, 32'h00000001);
    frag_go(1'b0, 1'b0);
    chk(32'(wr.buf_en[0]), 32'h001);
    chk(32'(wr.buf_en[1]), 32'h004);
    chk(32'(wr.buf_en[2]), 32'h000);
    chk(32'(wr.src_sel), 32'hf);
    chk(32'(rs), 32'h0);
  endtask

  task automatic t_errors();
    axi_wr(dts_pkg::OFF_CMD_LIST, lw(3'h5, dts_pkg::SEL_FR, 5'h00));
    rd_chk(dts_pkg::OFF_ERROR, 32'(dts_pkg::ERR_VALUE));
    rd_chk(dts_pkg::OFF_ERROR, 32'(dts_pkg::ERR_NONE));
    rd_chk(dts_pkg::OFF_TARGETS, 32'h00000061);
    axi_wr(dts_pkg::OFF_CMD_LIST, lw(3'h2, dts_pkg::SEL_FR, dts_pkg::SEL_FR));
    rd_chk(dts_pkg::OFF_ERROR, 32'(dts_pkg::ERR_OPERATION));
    for (int s = 5; s <= 9; s++) begin
      axi_wr(dts_pkg::OFF_CMD_LIST, lw(3'h1, 5'(s), 5'h00));
      rd_chk(dts_pkg::OFF_ERROR, 32'(dts_pkg::ERR_SELECTOR));
    end
    axi_wr(dts_pkg::OFF_CMD_CMASK, 32'h0000040f);
    rd_chk(dts_pkg::OFF_ERROR, 32'(dts_pkg::ERR_VALUE));
    rd_chk(dts_pkg::OFF_CMASKS, 32'h0000ffff);
  endtask

  task automatic t_masks();
    axi_wr(dts_pkg::OFF_CMD_CMASKALL, 32'h5);
    rd_chk(dts_pkg::OFF_CMASKS, 32'h00005555);
    axi_wr(dts_pkg::OFF_CMD_CMASK, 32'h0000020a);
    rd_chk(dts_pkg::OFF_CMASKS, 32'h00005a55);
    axi_wr(dts_pkg::OFF_DEPTH_EN, 32'h0);
    axi_wr(dts_pkg::OFF_INDEX_MASK, 32'h13c);
    axi_wr(dts_pkg::OFF_STEN_SIDED, 32'h10f);
    axi_wr(dts_pkg::OFF_STEN_SIDED, 32'h2f0);
    rd_chk(dts_pkg::OFF_STEN_RD, 32'h0000f00f);
    so <= 1'b1;
    frag_go(1'b1, 1'b0);
    chk(32'(wr.sten_mask), 32'hf0);
    chk(32'(wr.index_mask), 32'h3c);
    chk(32'(wr.depth_en), 32'h0);
    chk(32'(wr.comp_en[1]), 32'h5);
    chk(32'(wr.src_sel), 32'h0);
    frag_go(1'b1, 1'b1);
    chk(32'(wr.sten_mask), 32'h0f);
    axi_wr(dts_pkg::OFF_STEN_BOTH, 32'h33);
    rd_chk(dts_pkg::OFF_STEN_RD, 32'h00003333);
    axi_wr(dts_pkg::OFF_CMD_SINGLE, 32'(dts_pkg::SEL_FAB));
    rd_chk(dts_pkg::OFF_TARGETS, 32'h00000009);
    frag_go(1'b0, 1'b0);
    chk(32'(wr.buf_en[0]), 32'h00f);
    chk(32'(wr.comp_en[0]), 32'h5);
    chk(32'(wr.buf_en[1]), 32'h000);
  endtask

  task automatic t_attach();
    dfb <= 1'b0;
    att <= 4'h7;
    do_reset();
    rd_chk(dts_pkg::OFF_TARGET0, 32'(dts_pkg::SEL_ATT0));
    axi_wr(dts_pkg::OFF_CMD_LIST, lw(3'h2, 5'h13, 5'h11));
    ms <= 1'b1;
    axi_wr(dts_pkg::OFF_CMD_CMASKALL, 32'h0);
    frag_go(1'b0, 1'b0);
    chk(32'(wr.buf_en[0]), 32'h000);
    chk(32'(wr.buf_en[1]), 32'h080);
    chk(32'(rs), 32'h1);
    chk(32'(wr.comp_en[1]), 32'h0);
    axi_wr(dts_pkg::OFF_CMD_LIST, lw(3'h1, dts_pkg::SEL_FL, 5'h00));
    rd_chk(dts_pkg::OFF_ERROR, 32'(dts_pkg::ERR_OPERATION));
    axi_wr(dts_pkg::OFF_CMD_LIST, lw(3'h1, 5'h14, 5'h00));
    rd_chk(dts_pkg::OFF_ERROR, 32'(dts_pkg::ERR_OPERATION));
  endtask

  task automatic t_mono();
    st  <= 1'b0;
    db  <= 1'b0;
    dfb <= 1'b1;
    do_reset();
    rd_chk(dts_pkg::OFF_TARGET0, 32'(dts_pkg::SEL_FRONT));
    axi_wr(dts_pkg::OFF_CMD_LIST, lw(3'h1, dts_pkg::SEL_FR, 5'h00));
    rd_chk(dts_pkg::OFF_ERROR, 32'(dts_pkg::ERR_OPERATION));
    axi_wr(dts_pkg::OFF_CMD_LIST, lw(3'h1, dts_pkg::SEL_BL, 5'h00));
    rd_chk(dts_pkg::OFF_ERROR, 32'(dts_pkg::ERR_OPERATION));
    axi_wr(dts_pkg::OFF_CMD_LIST, lw(3'h1, dts_pkg::SEL_FL, 5'h00));
    rd_chk(dts_pkg::OFF_TARGETS, 32'h00000001);
    hdf <= 1'b0;
    do_reset();
    rd_chk(dts_pkg::OFF_TARGET0, 32'(dts_pkg::SEL_NONE));
  endtask

  initial begin
    do_reset();
    t_reset_vals();
    t_list();
    t_errors();
    t_masks();
    t_attach();
    t_mono();
    test_done();
  end
endmodule
